// ---- core/riru_top.sv ----
/*
 Reader interrupt request unit: sticky flags, enables, combined request and
 interrupt pin. Assumes event inputs synchronous to clk_i and a plain
 register port with read data one cycle after the read strobe.
*/
`timescale 1ns/10ps
module riru_top
   import riru_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // FIFO level status
   input wire logic fifo_low_level_status_i,
   input wire logic fifo_high_level_status_i,
   // Command sequencer
   input wire logic cmd_start_i,
   input wire logic [3:0] cmd_code_i,
   input wire logic cmd_done_i,
   output logic [3:0] active_cmd_o,
   // Transceiver events
   input wire logic tx_last_bit_i,
   input wire logic rx_stream_end_i,
   input wire logic buffer_write_fault_i,
   input wire logic buffer_overflow_fault_i,
   input wire logic framing_fault_i,
   input wire logic empty_send_fault_i,
   input wire logic integrity_fault_i,
   input wire logic sof_seen_i,
   input wire logic subcarrier_seen_i,
   // Card detection and timers
   input wire logic card_found_i,
   input wire logic [4:0] tmr_underflow_i,
   // Interrupt pin
   output logic irq_pin_o,
   output logic irq_pin_oe_o
);
   typedef struct packed {
      logic [7:0] en_first;
      logic [7:0] en_second;
      logic [7:0] rdata;
      logic low_prev;
      logic high_prev;
      logic combined;
      logic pin;
      logic pin_oe;
   } riru_top_s;
   riru_top_s state;
   riru_top_s next_state;

   logic [6:0] first_events;
   logic [5:0] second_events;
   logic [6:0] first_flags;
   logic [5:0] second_flags;
   logic idle_event;
   logic [3:0] active_cmd;
   logic wr_first;
   logic wr_second;
   logic any_fault;
   logic combined_now;
   logic pin_level;

   riru_cmd_watch u_cmd (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cmd_start_i(cmd_start_i),
      .cmd_code_i(cmd_code_i),
      .cmd_done_i(cmd_done_i),
      .active_cmd_o(active_cmd),
      .idle_event_o(idle_event)
   );

   always_comb begin
      any_fault = buffer_write_fault_i | buffer_overflow_fault_i | framing_fault_i
         | empty_send_fault_i | integrity_fault_i;
      first_events = '0;
      // Rising edges of the live levels, so a held level does not refight a clear.
      first_events[RIRU_BIT_LOW] = fifo_low_level_status_i & ~state.low_prev;
      first_events[RIRU_BIT_HIGH] = fifo_high_level_status_i & ~state.high_prev;
      first_events[RIRU_BIT_IDLE] = idle_event;
      first_events[RIRU_BIT_TX] = tx_last_bit_i;
      first_events[RIRU_BIT_RX] = rx_stream_end_i;
      first_events[RIRU_BIT_ERR] = any_fault;
      first_events[RIRU_BIT_SOF] = sof_seen_i | subcarrier_seen_i;
      second_events = {card_found_i, tmr_underflow_i};
      wr_first = reg_wr_i && reg_addr_i == RIRU_OFS_FLAGS_FIRST;
      wr_second = reg_wr_i && reg_addr_i == RIRU_OFS_FLAGS_SECOND;
   end

   riru_flag_bank #(
      .WIDTH(7)
   ) u_first (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .event_i(first_events),
      .wr_i(wr_first),
      .set_mode_i(reg_wdata_i[RIRU_BIT_SET]),
      .wr_bits_i(reg_wdata_i[6:0] & RIRU_FIRST_MASK),
      .flags_o(first_flags)
   );

   riru_flag_bank #(
      .WIDTH(6)
   ) u_second (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .event_i(second_events),
      .wr_i(wr_second),
      .set_mode_i(reg_wdata_i[RIRU_BIT_SET]),
      .wr_bits_i(reg_wdata_i[5:0] & RIRU_SECOND_MASK),
      .flags_o(second_flags)
   );

   always_comb begin
      next_state = state;
      next_state.low_prev = fifo_low_level_status_i;
      next_state.high_prev = fifo_high_level_status_i;
      combined_now = |(first_flags & state.en_first[6:0])
         | |(second_flags & state.en_second[5:0]);
      next_state.combined = combined_now;
      pin_level = (state.combined & state.en_second[RIRU_BIT_PIN_GATE])
         ^ state.en_first[RIRU_BIT_INVERT];
      next_state.pin = pin_level;
      // Open drain drives only the low level; high is left to the pull-up.
      next_state.pin_oe = state.en_second[RIRU_BIT_PUSHPULL] | ~pin_level;
      if (reg_wr_i && reg_addr_i == RIRU_OFS_EN_FIRST) begin
         next_state.en_first = reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == RIRU_OFS_EN_SECOND) begin
         next_state.en_second = reg_wdata_i;
      end
      next_state.rdata = RIRU_RESET_VALUE;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            RIRU_OFS_FLAGS_FIRST: next_state.rdata = {1'b0, first_flags};
            RIRU_OFS_FLAGS_SECOND: next_state.rdata = {1'b0, state.combined, second_flags};
            RIRU_OFS_EN_FIRST: next_state.rdata = state.en_first;
            RIRU_OFS_EN_SECOND: next_state.rdata = state.en_second;
            default: next_state.rdata = RIRU_RESET_VALUE;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= '0;
         state.pin_oe <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata_o = state.rdata;
   assign irq_pin_o = state.pin;
   assign irq_pin_oe_o = state.pin_oe;
   assign active_cmd_o = active_cmd;

   a_combined_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (state.combined == $past(|(first_flags & state.en_first[6:0])
         | |(second_flags & state.en_second[5:0]))))
      else $error("combined request wrong");
   a_pin_level: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (irq_pin_o == $past((state.combined & state.en_second[6]) ^ state.en_first[7])))
      else $error("pin level wrong");
   // Pin and enable are registered from the drive select of the cycle before.
   a_open_drain_high: assert property (@(posedge clk_i) disable iff (rst_i)
      (!$past(state.en_second[7]) && irq_pin_o) |-> !irq_pin_oe_o)
      else $error("open drain drove high");
   a_low_latched: assert property (@(posedge clk_i) disable iff (rst_i)
      (fifo_low_level_status_i && !state.low_prev) |=> first_flags[5])
      else $error("low level flag missed");
   a_high_latched: assert property (@(posedge clk_i) disable iff (rst_i)
      (fifo_high_level_status_i && !state.high_prev) |=> first_flags[6])
      else $error("high level flag missed");
   a_fault_sets_err: assert property (@(posedge clk_i) disable iff (rst_i)
      any_fault |=> first_flags[1])
      else $error("fault did not set error flag");
   a_timer_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      tmr_underflow_i[4] |=> second_flags[4])
      else $error("timer flag missed");
endmodule

// ---- core/riru_pkg.sv ----
/*
 Constants shared by the reader interrupt request unit: register offsets,
 field positions and reset values. Assumes an 8-bit register port.
*/
// What this block does
// - Latch FIFO low-level flag in bit five.
// - Latch FIFO high-level flag in bit six.
// - Idle flag when command ends by itself.
// - Unknown command reverts idle, sets idle flag.
// - Host-started idle command sets no flag.
// - Transmit-done flag after last bit sent.
// - Receive-end flag at stream end, any validity.
// - Error flag on any listed fault.
// - Frame-start flag on SOF or subcarrier.
// - First flags: bit seven selects set/clear.
// - Second flags: bit seven selects set/clear.
// - Combined request: any enabled flag set.
// - Card-presence flag when card detected.
// - Five timer underflow flags, bits four-zero.
// - First enables gate first flags.
// - Enable bit five gates card-presence flag.
// - Enable bits four-zero gate timer flags.
// - First enable bit seven inverts pin.
// - Second enable bit seven: push-pull else open-drain.
// - Pin enable gates combined request to pin.
package riru_pkg;
   localparam logic [7:0] RIRU_OFS_FLAGS_FIRST = 8'h06;
   localparam logic [7:0] RIRU_OFS_FLAGS_SECOND = 8'h07;
   localparam logic [7:0] RIRU_OFS_EN_FIRST = 8'h08;
   localparam logic [7:0] RIRU_OFS_EN_SECOND = 8'h09;
   localparam int RIRU_BIT_SET = 7;
   localparam int RIRU_BIT_HIGH = 6;
   localparam int RIRU_BIT_LOW = 5;
   localparam int RIRU_BIT_IDLE = 4;
   localparam int RIRU_BIT_TX = 3;
   localparam int RIRU_BIT_RX = 2;
   localparam int RIRU_BIT_ERR = 1;
   localparam int RIRU_BIT_SOF = 0;
   localparam int RIRU_BIT_COMBINED = 6;
   localparam int RIRU_BIT_CARD = 5;
   localparam int RIRU_BIT_INVERT = 7;
   localparam int RIRU_BIT_PUSHPULL = 7;
   localparam int RIRU_BIT_PIN_GATE = 6;
   localparam logic [6:0] RIRU_FIRST_MASK = 7'h7F;
   localparam logic [5:0] RIRU_SECOND_MASK = 6'h3F;
   localparam logic [7:0] RIRU_RESET_VALUE = 8'h00;
   localparam logic [3:0] RIRU_CMD_IDLE = 4'h0;
   localparam logic [3:0] RIRU_CMD_LAST_KNOWN = 4'hD;
endpackage

// ---- core/riru_flag_bank.sv ----
/*
 Sticky flag bank with a set/clear write port. Assumes event inputs are
 one-cycle pulses or levels synchronous to clk_i.
*/
`timescale 1ns/10ps
module riru_flag_bank
   import riru_pkg::*;
#(
   parameter int WIDTH = 7
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Events and software access
   input wire logic [WIDTH-1:0] event_i,
   input wire logic wr_i,
   input wire logic set_mode_i,
   input wire logic [WIDTH-1:0] wr_bits_i,
   // Flags
   output logic [WIDTH-1:0] flags_o
);
   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } riru_bank_s;
   riru_bank_s state;
   riru_bank_s next_state;

   // The set/clear write carries its mode in bit 7, so at most seven flags fit.
   if (WIDTH < 1 || WIDTH > 7) begin
      $error("riru_flag_bank: WIDTH out of range");
   end

   // A software clear never hides an event arriving in the same cycle.
   always_comb begin
      next_state = state;
      if (wr_i && set_mode_i) begin
         next_state.flags = state.flags | wr_bits_i;
      end else if (wr_i) begin
         next_state.flags = state.flags & ~wr_bits_i;
      end
      next_state.flags = next_state.flags | event_i;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign flags_o = state.flags;

   a_event_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (|event_i) |=> ((flags_o & $past(event_i)) == $past(event_i)))
      else $error("event did not set its flag");
   a_flag_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      (!wr_i || set_mode_i) |=> ((flags_o & $past(flags_o)) == $past(flags_o)))
      else $error("flag dropped without clear");
endmodule

// ---- core/riru_cmd_watch.sv ----
/*
 Watches the command register and raises the idle event. Assumes the
 command sequencer reports self termination with a one-cycle pulse.
*/
`timescale 1ns/10ps
module riru_cmd_watch
   import riru_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Command side
   input wire logic cmd_start_i,
   input wire logic [3:0] cmd_code_i,
   input wire logic cmd_done_i,
   // Results
   output logic [3:0] active_cmd_o,
   output logic idle_event_o
);
   typedef struct packed {
      logic [3:0] active;
      logic idle_event;
   } riru_cmd_s;
   riru_cmd_s state;
   riru_cmd_s next_state;

   always_comb begin
      next_state = state;
      next_state.idle_event = 1'b0;
      if (cmd_start_i) begin
         if (cmd_code_i == RIRU_CMD_IDLE) begin
            next_state.active = RIRU_CMD_IDLE;
         end else if (cmd_code_i > RIRU_CMD_LAST_KNOWN) begin
            next_state.active = RIRU_CMD_IDLE;
            next_state.idle_event = 1'b1;
         end else begin
            next_state.active = cmd_code_i;
         end
      end else if (cmd_done_i && state.active != RIRU_CMD_IDLE) begin
         next_state.active = RIRU_CMD_IDLE;
         next_state.idle_event = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign active_cmd_o = state.active;
   assign idle_event_o = state.idle_event;

   a_host_idle_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      (cmd_start_i && cmd_code_i == RIRU_CMD_IDLE) |=> !idle_event_o)
      else $error("host idle start raised idle event");
   a_unknown_reverts: assert property (@(posedge clk_i) disable iff (rst_i)
      (cmd_start_i && cmd_code_i > RIRU_CMD_LAST_KNOWN)
      |=> (idle_event_o && active_cmd_o == RIRU_CMD_IDLE))
      else $error("unknown command not reverted");
endmodule

// ---- tb/riru_host.sv ----
/*
 Host model: drives the register port and watches the interrupt pin.
 Assumes a pull-up on the interrupt line, so a released line reads high.
*/
`timescale 1ns/10ps
module riru_host (
   // Clock
   input wire logic clk_i,
   // Register port
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   input wire logic [7:0] reg_rdata_i,
   // Interrupt pin
   input wire logic irq_pin_i,
   input wire logic irq_pin_oe_i,
   output logic pin_level_o
);
   // In open drain the block only pulls low, so the pull-up sets the high level.
   assign pin_level_o = irq_pin_oe_i ? irq_pin_i : 1'b1;
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      #1 d = reg_rdata_i;
   endtask
endmodule

// ---- tb/testbench.sv ----
/*
 Self-checking bench for the interrupt request unit: register access,
 sticky flags, command watch and pin drive. Assumes the host model beside it.
*/
`timescale 1ns/10ps
module testbench;
   import riru_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [16:0] ev = '0;
   logic cmd_start = 1'b0;
   logic cmd_done = 1'b0;
   logic [3:0] cmd_code = 4'h0;
   logic [7:0] addr, wdata, rdata, seed, f0, f1, e0, e1;
   logic wr, rd, irq_pin, irq_oe, pin_level;
   logic [3:0] act;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   always #4 clk_i = ~clk_i;
   riru_host host (.clk_i(clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
      .reg_rd_o(rd), .reg_rdata_i(rdata), .irq_pin_i(irq_pin), .irq_pin_oe_i(irq_oe),
      .pin_level_o(pin_level));
   riru_top dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .fifo_low_level_status_i(ev[0]),
      .fifo_high_level_status_i(ev[1]), .cmd_start_i(cmd_start), .cmd_code_i(cmd_code),
      .cmd_done_i(cmd_done), .active_cmd_o(act), .tx_last_bit_i(ev[2]),
      .rx_stream_end_i(ev[3]), .buffer_write_fault_i(ev[4]), .buffer_overflow_fault_i(ev[5]),
      .framing_fault_i(ev[6]), .empty_send_fault_i(ev[7]), .integrity_fault_i(ev[8]),
      .sof_seen_i(ev[9]), .subcarrier_seen_i(ev[10]), .card_found_i(ev[11]),
      .tmr_underflow_i(ev[16:12]), .irq_pin_o(irq_pin), .irq_pin_oe_o(irq_oe));
   function automatic logic [7:0] nxt(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic comb();
      return (|(f0[6:0] & e0[6:0])) | (|(f1[5:0] & e1[5:0]));
   endfunction
   // Expected {second, first} flags after event input i pulses once.
   function automatic logic [15:0] evexp(input int i);
      if (i < 2) return 16'h0020 << i;
      if (i < 4) return 16'h0008 >> (i - 2);
      if (i < 9) return 16'h0002;
      if (i < 11) return 16'h0001;
      if (i == 11) return 16'h2000;
      return 16'h0100 << (i - 12);
   endfunction
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic check_all();
      logic [7:0] d;
      logic lvl;
      host.rd(8'h06, d);
      chk(d, f0);
      host.rd(8'h07, d);
      chk(d, {1'b0, comb(), f1[5:0]});
      host.rd(8'h08, d);
      chk(d, e0);
      host.rd(8'h09, d);
      chk(d, e1);
      host.rd(8'h0A, d);
      chk(d, 8'h00);
      lvl = (comb() & e1[6]) ^ e0[7];
      chk({7'h00, irq_pin}, {7'h00, lvl});
      chk({7'h00, irq_oe}, {7'h00, e1[7] | ~lvl});
      chk({7'h00, pin_level}, {7'h00, lvl});
   endtask
   task automatic step(input logic [7:0] a, input logic [7:0] d);
      host.wr(a, d);
      case (a)
         8'h06: f0 = d[7] ? (f0 | {1'b0, d[6:0]}) : (f0 & ~{1'b0, d[6:0]});
         8'h07: f1 = d[7] ? (f1 | {2'b00, d[5:0]}) : (f1 & ~{2'b00, d[5:0]});
         8'h08: e0 = d;
         8'h09: e1 = d;
         default: ;
      endcase
      check_all();
   endtask
   task automatic cmd(input logic s, input logic [3:0] c, input logic d, input logic [3:0] ea,
      input logic ef);
      @(posedge clk_i);
      cmd_start <= s;
      cmd_code <= c;
      cmd_done <= d;
      @(posedge clk_i);
      cmd_start <= 1'b0;
      cmd_done <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk({4'h0, act}, {4'h0, ea});
      f0 = ef ? 8'h10 : 8'h00;
      check_all();
      step(8'h06, 8'h10);
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 8000) begin
         num_errors++;
         results();
      end
   end
   initial begin
      seed = 8'h52;
      {f0, f1, e0, e1} = '0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      check_all();
      $display("reset test done");
      step(8'h06, 8'hFF);
      step(8'h07, 8'hFF);
      step(8'h08, 8'h7F);
      step(8'h09, 8'h7F);
      step(8'h0A, 8'hFF);
      step(8'h06, 8'h7F);
      step(8'h07, 8'h3F);
      for (int i = 0; i < 40; i++) begin
         seed = nxt(seed);
         addr_pick: begin
            logic [7:0] a;
            a = 8'h05 + {5'h00, seed[2:0]};
            seed = nxt(seed);
            step(a, seed);
         end
      end
      $display("register test done");
      step(8'h06, 8'h7F);
      step(8'h07, 8'h3F);
      step(8'h08, 8'h00);
      step(8'h09, 8'h00);
      for (int i = 0; i < 17; i++) begin
         @(posedge clk_i);
         ev <= 17'h00001 << i;
         @(posedge clk_i);
         ev <= '0;
         {f1, f0} = evexp(i);
         check_all();
         step(8'h06, 8'h7F);
         step(8'h07, 8'h3F);
      end
      // An event and a software clear in one cycle: the event must win.
      fork
         host.wr(8'h06, 8'h08);
         begin
            @(posedge clk_i);
            ev <= 17'h00004;
            @(posedge clk_i);
            ev <= '0;
         end
      join
      f0 = 8'h08;
      check_all();
      step(8'h06, 8'h7F);
      $display("event test done");
      cmd(1'b1, 4'h3, 1'b0, 4'h3, 1'b0);
      cmd(1'b0, 4'h0, 1'b1, 4'h0, 1'b1);
      cmd(1'b1, 4'hD, 1'b0, 4'hD, 1'b0);
      cmd(1'b1, 4'h0, 1'b0, 4'h0, 1'b0);
      cmd(1'b1, 4'hF, 1'b0, 4'h0, 1'b1);
      $display("command test done");
      cmd(1'b1, 4'h5, 1'b0, 4'h5, 1'b0);
      step(8'h09, 8'hC0);
      step(8'h06, 8'hFF);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      {f0, f1, e0, e1} = '0;
      check_all();
      chk({4'h0, act}, 8'h00);
      $display("second reset test done");
      results();
   end
endmodule
